// ==== hdl/cit_pkg.sv ====
// Summary of operation
// RULE1: No instruction exceeds eight system clocks.
// RULE2: 109 instructions, fixed per-class cycle counts.
// RULE3: Timing counted in plain clocks only.
// RULE4: Most instructions take one clock per byte.
// RULE5: Untaken branch finishes one clock earlier.
// RULE6: Classic opcodes, modes, flags; timing differs.
// RULE7: Breakpoints, watchpoints, run, halt, single step.
// RULE8: Debug uses no user resources, full speed.
// RULE9: Test port programs flash, reaches debug logic.
// RULE10: MOVC reads, MOVX writes program flash.
// RULE11: Two-count branches: low untaken, high taken.
package cit_pkg;

	localparam int          CIT_CYC_W      = 4;
	localparam logic [3:0]  CIT_MAX_CYCLES = 4'h8;
	localparam logic [3:0]  CIT_CNT_RST    = 4'h0;
	localparam logic [3:0]  CIT_CNT_FIRST  = 4'h1;
	localparam logic [3:0]  CIT_CYC_RST    = 4'h0;
	localparam int          CIT_ADDR_W     = 16;

	// Sequencer states, one-hot
	typedef enum logic [1:0] {
		CIT_SEQ_IDLE = 2'b01,
		CIT_SEQ_EXEC = 2'b10
	} cit_seq_t;

	// Debug states, one-hot
	typedef enum logic [2:0] {
		CIT_DBG_RUN  = 3'b001,
		CIT_DBG_HALT = 3'b010,
		CIT_DBG_STEP = 3'b100
	} cit_dbg_t;

	// Per-opcode timing record
	typedef struct packed {
		logic [1:0] len;
		logic [3:0] base;
		logic       cond;
		logic       movc;
		logic       movx_wr;
	} cit_timing_t;

	// Debug commands from the test-port logic, one-cycle pulses
	typedef struct packed {
		logic halt;
		logic run;
		logic step;
	} cit_dbg_cmd_t;

	// Address comparator setting
	typedef struct packed {
		logic                  en;
		logic [CIT_ADDR_W-1:0] addr;
	} cit_match_t;

	// Opcode to length and cycle count; the encoding map is the classic one
	function automatic cit_timing_t cit_decode(input logic [7:0] op);
		cit_timing_t t;
		logic [3:0]  hi;
		t  = '0;
		hi = op[7:4];
		// Instruction length in bytes
		case (op[3:0])
			4'h0: t.len = (hi inside {4'h1, 4'h2, 4'h3, 4'h9}) ? 2'h3 :
				(hi inside {4'h0, 4'hE, 4'hF}) ? 2'h1 : 2'h2;
			4'h1: t.len = 2'h2;
			4'h2: t.len = (hi inside {4'h0, 4'h1}) ? 2'h3 :
				(hi inside {4'h2, 4'h3, 4'hE, 4'hF}) ? 2'h1 : 2'h2;
			4'h3: t.len = (hi inside {4'h4, 4'h5, 4'h6}) ? 2'h3 : 2'h1;
			4'h4: t.len = (hi inside {4'h0, 4'h1, 4'h8, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF}) ? 2'h1 :
				(hi == 4'hB) ? 2'h3 : 2'h2;
			4'h5: t.len = (hi inside {4'h7, 4'h8, 4'hB, 4'hD}) ? 2'h3 : (hi == 4'hA) ? 2'h1 : 2'h2;
			4'h6, 4'h7: t.len = (hi inside {4'h7, 4'h8, 4'hA}) ? 2'h2 : (hi == 4'hB) ? 2'h3 : 2'h1;
			default: t.len = (hi inside {4'h7, 4'h8, 4'hA, 4'hD}) ? 2'h2 : (hi == 4'hB) ? 2'h3 : 2'h1;
		endcase
		// Default: one clock per program byte [RULE4] [RULE3]
		t.base = {2'h0, t.len};
		// One-byte indirect accesses need a second clock
		if ((op[3:1] == 3'h3) && (t.len == 2'h1))
			t.base = 4'h2;
		// Exceptions to the byte rule [RULE2]
		case (op)
			8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: t.base = 4'h3;
			8'h83, 8'h93, 8'h73, 8'h80:                t.base = 4'h3;
			8'hA4, 8'h02, 8'h12:                       t.base = 4'h4;
			8'h22, 8'h32:                              t.base = 4'h5;
			8'h84:                                     t.base = CIT_MAX_CYCLES; // [RULE1]
			default: ;
		endcase
		if (op[3:0] == 4'h1)
			t.base = 4'h3;
		// Conditional branches; base is the untaken count [RULE11]
		t.cond = (op[3:0] == 4'h0 && hi inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7}) ||
			(hi == 4'hB && op[3:2] != 2'h0) || op == 8'hD5 || (hi == 4'hD && op[3]);
		if (op == 8'hB6 || op == 8'hB7)
			t.base = 4'h4;
		t.movc    = (op == 8'h83) || (op == 8'h93);
		t.movx_wr = (op == 8'hF0) || (op == 8'hF2) || (op == 8'hF3);
		return t;
	endfunction

endpackage

// ==== hdl/cit_addr_match.sv ====
`timescale 1ns/1ps
// Address comparator for breakpoints and watchpoints
module cit_addr_match #(
	parameter int W = 16
) (
	input  wire logic         en,
	input  wire logic [W-1:0] ref_addr,
	input  wire logic         probe_vld,
	input  wire logic [W-1:0] probe_addr,
	output logic              hit
);
	// Dedicated comparator, so no user resources are borrowed
	assign hit = en && probe_vld && (probe_addr == ref_addr); // [RULE8]
endmodule

// ==== hdl/cit_core_timing.sv ====
`timescale 1ns/1ps
// Instruction timing sequencer with debug run control
module cit_core_timing (
	input  wire logic                        REF_CLK,
	input  wire logic                        ARST_N,
	input  wire logic                        OP_VALID,
	output logic                             OP_READY,
	input  wire logic [7:0]                  OPCODE,
	input  wire logic [cit_pkg::CIT_ADDR_W-1:0] OP_PC,
	input  wire logic                        BRANCH_TAKEN,
	output logic                             FETCH_STB,
	output logic                             INSTR_DONE,
	output logic [3:0]                       LAST_CYCLES,
	output logic [7:0]                       LAST_OPCODE,
	input  wire logic                        FLASH_WR_EN,
	output logic                             FLASH_RD_STB,
	output logic                             FLASH_WR_STB,
	input  wire logic                        DATA_ACC_STB,
	input  wire logic [cit_pkg::CIT_ADDR_W-1:0] DATA_ACC_ADDR,
	input  wire cit_pkg::cit_dbg_cmd_t       DBG_CMD,
	input  wire cit_pkg::cit_match_t         DBG_BREAK,
	input  wire cit_pkg::cit_match_t         DBG_WATCH,
	output logic                             DBG_HALTED,
	input  wire logic                        DBG_ACC_REQ,
	output logic                             DBG_ACC_GNT,
	input  wire logic                        TP_PGM_REQ,
	output logic                             TP_PGM_GNT
);
	import cit_pkg::*;

	cit_seq_t    seq_r;
	cit_seq_t    seq_nxt;
	logic [3:0]  cnt_r;
	logic [3:0]  cnt_nxt;
	cit_timing_t info_r;
	cit_timing_t info_nxt;
	logic        ext_r;
	logic        ext_nxt;
	logic [3:0]  last_cyc_r;
	logic [3:0]  last_cyc_nxt;
	logic [7:0]  last_op_r;
	logic [7:0]  last_op_nxt;
	logic [7:0]  op_r;
	logic [7:0]  op_nxt;
	logic        rd_stb_r;
	logic        rd_stb_nxt;
	logic        wr_stb_r;
	logic        wr_stb_nxt;
	cit_dbg_t    dbg_r;
	cit_dbg_t    dbg_nxt;
	logic        halt_pend_r;
	logic        halt_pend_nxt;
	logic        step_used_r;
	logic        step_used_nxt;
	logic        bp_skip_r;
	logic        bp_skip_nxt;
	logic        done;
	logic        boundary;
	logic        issue_ok;
	logic        bp_hit;
	logic        wp_hit;
	logic        bp_stop;
	logic        accept;
	cit_timing_t dec;

	// Breakpoint on the address of the next instruction
	cit_addr_match #(.W(CIT_ADDR_W)) u_break (
		.en         (DBG_BREAK.en),
		.ref_addr   (DBG_BREAK.addr),
		.probe_vld  (OP_VALID),
		.probe_addr (OP_PC),
		.hit        (bp_hit)
	);

	// Watchpoint on data accesses
	cit_addr_match #(.W(CIT_ADDR_W)) u_watch (
		.en         (DBG_WATCH.en),
		.ref_addr   (DBG_WATCH.addr),
		.probe_vld  (DATA_ACC_STB),
		.probe_addr (DATA_ACC_ADDR),
		.hit        (wp_hit)
	);

	// Opcode decode; function and flags untouched, only timing is ours [RULE6]
	assign dec = cit_decode(OPCODE);

	// Finish at base, or one clock later when the branch is taken [RULE5] [RULE11]
	assign done = (seq_r == CIT_SEQ_EXEC) &&
		(ext_r || ((cnt_r == info_r.base) && !(info_r.cond && BRANCH_TAKEN)));
	assign boundary = (seq_r == CIT_SEQ_IDLE) || done;

	// Issue only while running, or once per step [RULE7]
	assign issue_ok = ((dbg_r == CIT_DBG_RUN) && !halt_pend_r) ||
		((dbg_r == CIT_DBG_STEP) && !step_used_r);
	// Breakpoint stops before the matching instruction issues [RULE7]
	assign bp_stop  = issue_ok && bp_hit && !bp_skip_r && boundary;
	// Back-to-back issue in the last clock keeps full pipeline rate
	assign OP_READY = issue_ok && boundary && !(bp_hit && !bp_skip_r);
	assign accept   = OP_VALID && OP_READY;

	// Sequencer next state
	always_comb begin
		seq_nxt      = seq_r;
		cnt_nxt      = cnt_r;
		info_nxt     = info_r;
		ext_nxt      = ext_r;
		last_cyc_nxt = last_cyc_r;
		last_op_nxt  = last_op_r;
		op_nxt       = op_r;
		rd_stb_nxt   = 1'b0;
		wr_stb_nxt   = 1'b0;
		case (seq_r)
			CIT_SEQ_IDLE: begin
				cnt_nxt = CIT_CNT_RST;
			end
			CIT_SEQ_EXEC: begin
				// Plain clock count, no machine cycles [RULE3]
				cnt_nxt = cnt_r + 4'h1;
				if (!ext_r && (cnt_r == info_r.base) && info_r.cond && BRANCH_TAKEN)
					ext_nxt = 1'b1; // [RULE11]
				if (done) begin
					seq_nxt      = CIT_SEQ_IDLE;
					ext_nxt      = 1'b0;
					cnt_nxt      = CIT_CNT_RST;
					last_cyc_nxt = cnt_r; // [RULE1]
					last_op_nxt  = op_r;
				end
			end
			default: begin
				seq_nxt = CIT_SEQ_IDLE;
			end
		endcase
		if (accept) begin
			seq_nxt  = CIT_SEQ_EXEC;
			cnt_nxt  = CIT_CNT_FIRST;
			info_nxt = dec;
			ext_nxt  = 1'b0;
			op_nxt   = OPCODE;
			// Application code reaching program flash [RULE10]
			rd_stb_nxt = dec.movc;
			wr_stb_nxt = dec.movx_wr && FLASH_WR_EN;
		end
	end

	// Sequencer registers
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			seq_r      <= CIT_SEQ_IDLE;
			cnt_r      <= CIT_CNT_RST;
			info_r     <= '0;
			ext_r      <= 1'b0;
			last_cyc_r <= CIT_CYC_RST;
			last_op_r  <= 8'h00;
			op_r       <= 8'h00;
			rd_stb_r   <= 1'b0;
			wr_stb_r   <= 1'b0;
		end else begin
			seq_r      <= seq_nxt;
			cnt_r      <= cnt_nxt;
			info_r     <= info_nxt;
			ext_r      <= ext_nxt;
			last_cyc_r <= last_cyc_nxt;
			last_op_r  <= last_op_nxt;
			op_r       <= op_nxt;
			rd_stb_r   <= rd_stb_nxt;
			wr_stb_r   <= wr_stb_nxt;
		end
	end

	// Debug control next state; an interrupt entry is just another issued instruction,
	// so stepping walks into service routines the same way
	always_comb begin
		dbg_nxt       = dbg_r;
		halt_pend_nxt = halt_pend_r || DBG_CMD.halt || wp_hit; // [RULE7]
		step_used_nxt = step_used_r;
		bp_skip_nxt   = bp_skip_r && !accept;
		case (dbg_r)
			CIT_DBG_RUN: begin
				if (bp_stop || (halt_pend_nxt && boundary && !accept)) begin
					dbg_nxt       = CIT_DBG_HALT;
					halt_pend_nxt = 1'b0;
				end
			end
			CIT_DBG_HALT: begin
				halt_pend_nxt = 1'b0;
				// Skip lets execution leave the breakpoint it stopped on
				if (DBG_CMD.step) begin
					dbg_nxt       = CIT_DBG_STEP;
					step_used_nxt = 1'b0;
					bp_skip_nxt   = 1'b1;
				end else if (DBG_CMD.run) begin
					dbg_nxt     = CIT_DBG_RUN;
					bp_skip_nxt = 1'b1;
				end
			end
			CIT_DBG_STEP: begin
				if (accept)
					step_used_nxt = 1'b1;
				if (step_used_r && boundary) begin
					dbg_nxt       = CIT_DBG_HALT; // [RULE7]
					halt_pend_nxt = 1'b0;
				end
			end
			default: begin
				dbg_nxt = CIT_DBG_HALT;
			end
		endcase
	end

	// Debug registers
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			dbg_r       <= CIT_DBG_RUN;
			halt_pend_r <= 1'b0;
			step_used_r <= 1'b0;
			bp_skip_r   <= 1'b0;
		end else begin
			dbg_r       <= dbg_nxt;
			halt_pend_r <= halt_pend_nxt;
			step_used_r <= step_used_nxt;
			bp_skip_r   <= bp_skip_nxt;
		end
	end

	// One program byte fetched per clock over the first len clocks of the instruction [RULE4]
	assign FETCH_STB    = (seq_r == CIT_SEQ_EXEC) && !ext_r && (cnt_r <= {2'h0, info_r.len});
	assign INSTR_DONE   = done;
	assign LAST_CYCLES  = last_cyc_r;
	assign LAST_OPCODE  = last_op_r;
	assign FLASH_RD_STB = rd_stb_r;
	assign FLASH_WR_STB = wr_stb_r;
	assign DBG_HALTED   = (dbg_r == CIT_DBG_HALT);
	// Register, memory and stack reads by the debugger only while halted [RULE8]
	assign DBG_ACC_GNT  = (dbg_r == CIT_DBG_HALT) && DBG_ACC_REQ; // [RULE7]
	// Test-port flash programming only while the core is stopped [RULE9]
	assign TP_PGM_GNT   = (dbg_r == CIT_DBG_HALT) && TP_PGM_REQ;
endmodule

// ==== tb/cit_core_timing_properties.sv ====
`timescale 1ns/1ps
// Port-level timing and debug checks
module cit_core_timing_chk (
	input wire logic                  REF_CLK,
	input wire logic                  ARST_N,
	input wire logic                  OP_VALID,
	input wire logic                  OP_READY,
	input wire logic [7:0]            OPCODE,
	input wire logic                  BRANCH_TAKEN,
	input wire logic                  FETCH_STB,
	input wire logic                  INSTR_DONE,
	input wire logic [3:0]            LAST_CYCLES,
	input wire logic                  FLASH_WR_EN,
	input wire logic                  FLASH_RD_STB,
	input wire logic                  FLASH_WR_STB,
	input wire cit_pkg::cit_dbg_cmd_t DBG_CMD,
	input wire logic                  DBG_HALTED,
	input wire logic                  DBG_ACC_REQ,
	input wire logic                  DBG_ACC_GNT,
	input wire logic                  TP_PGM_REQ,
	input wire logic                  TP_PGM_GNT
);
	import cit_pkg::*;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	logic iss;
	// Opcode taken at this edge
	assign iss = OP_VALID && OP_READY;
	done_bound_a: assert property (iss |-> ##[1:8] INSTR_DONE) else $error("done late");
	cyc_range_a: assert property (INSTR_DONE |=> LAST_CYCLES inside {[4'h1:4'h8]}) else $error("bad count");
	fetch_first_a: assert property (iss |=> FETCH_STB) else $error("no fetch");
	nop_one_a: assert property (iss && OPCODE == 8'h00 |=> INSTR_DONE) else $error("nop slow");
	div_eight_a: assert property (iss && OPCODE == 8'h84 |=> !INSTR_DONE [*7] ##1 INSTR_DONE) else $error("div");
	// Branch at clock two decides between two and three clocks
	branch_short_a: assert property (iss && OPCODE == 8'h40 ##2 1 |-> INSTR_DONE == !BRANCH_TAKEN) else $error("br");
	taken_late_a: assert property (iss && OPCODE == 8'h40 ##2 BRANCH_TAKEN |=> INSTR_DONE) else $error("tk");
	halt_block_a: assert property (DBG_HALTED |-> !OP_READY) else $error("issue while halted");
	run_resume_a: assert property (DBG_HALTED && DBG_CMD.run |=> !DBG_HALTED) else $error("no resume");
	grant_gate_a: assert property (TP_PGM_GNT == (DBG_HALTED && TP_PGM_REQ) && DBG_ACC_GNT == (DBG_HALTED && DBG_ACC_REQ))
		else $error("grant");
	movc_read_a: assert property (iss && OPCODE inside {8'h83, 8'h93} |=> FLASH_RD_STB) else $error("rd");
	movx_gate_a: assert property (iss && OPCODE == 8'hF0 |=> FLASH_WR_STB == $past(FLASH_WR_EN)) else $error("wr");
endmodule
bind cit_core_timing cit_core_timing_chk u_chk (.*);

// ==== tb/cit_dbg_host.sv ====
`timescale 1ns/1ps
// External debugger and programmer behind the test port
module cit_dbg_host (
	input wire logic              clk,
	output cit_pkg::cit_dbg_cmd_t cmd,
	output logic                  acc_req,
	output logic                  pgm_req
);
	import cit_pkg::*;
	initial begin
		cmd = '0;
		acc_req = 1'b0;
		pgm_req = 1'b0;
	end
	// One-clock command pulse, changed only off the falling edge
	task automatic pulse(input cit_dbg_cmd_t c);
		@(negedge clk);
		cmd = c;
		@(negedge clk);
		cmd = '0;
	endtask
	// Memory and flash access requests; the core grants them only when halted
	task automatic req(input logic v);
		@(negedge clk);
		acc_req = v;
		pgm_req = v;
	endtask
endmodule

// ==== tb/cit_core_timing_tb_top.sv ====
`timescale 1ns/1ps
module core_instruction_timing_tb_top;
	import cit_pkg::*;
	logic clk, rst_n, vld, btk, wen, dstb;
	logic [7:0] op;
	logic [15:0] pc, daddr;
	cit_match_t brk, wat;
	cit_dbg_cmd_t cmd;
	logic rdy, fst, done, rds, wrs, hlt, areq, agnt, preq, pgnt;
	logic [3:0] lcyc;
	logic [7:0] lop;
	int errors = 0, checks_done = 0, ndone = 0, nfet = 0, nrd = 0, nwr = 0;
	// Clock starts low so the first edge is a clean rise
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	cit_dbg_host host (.clk(clk), .cmd(cmd), .acc_req(areq), .pgm_req(preq));
	cit_core_timing DUT (.REF_CLK(clk), .ARST_N(rst_n), .OP_VALID(vld), .OP_READY(rdy), .OPCODE(op), .OP_PC(pc),
		.BRANCH_TAKEN(btk), .FETCH_STB(fst), .INSTR_DONE(done), .LAST_CYCLES(lcyc), .LAST_OPCODE(lop),
		.FLASH_WR_EN(wen), .FLASH_RD_STB(rds), .FLASH_WR_STB(wrs), .DATA_ACC_STB(dstb), .DATA_ACC_ADDR(daddr),
		.DBG_CMD(cmd), .DBG_BREAK(brk), .DBG_WATCH(wat), .DBG_HALTED(hlt), .DBG_ACC_REQ(areq),
		.DBG_ACC_GNT(agnt), .TP_PGM_REQ(preq), .TP_PGM_GNT(pgnt));
	// Count pulses mid-cycle, where they have settled
	always @(negedge clk) begin
		if (done === 1'b1)
			ndone++;
		if (fst === 1'b1)
			nfet++;
		if (rds === 1'b1)
			nrd++;
		if (wrs === 1'b1)
			nwr++;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("errors=%0d checks=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Offer one opcode, return clocks until its completion pulse
	task automatic issue(input logic [7:0] o, input logic t, output int n);
		n = 0;
		@(negedge clk);
		vld = 1;
		op = o;
		btk = t;
		#1;
		while (rdy !== 1'b1 && n < 100) begin
			@(negedge clk);
			#1;
			n++;
		end
		@(negedge clk);
		vld = 0;
		n = 1;
		while (done !== 1'b1 && n < 12) begin
			@(negedge clk);
			n++;
		end
	endtask
	// Cycle counts across classes, branches both ways, flash strobes
	task automatic t_timing;
		logic [7:0] ops [15] = '{8'h00, 8'h25, 8'h26, 8'h75, 8'h93, 8'hF0, 8'hF0, 8'hA4, 8'h84, 8'h22, 8'h02,
			8'h40, 8'h40, 8'hB4, 8'hB4};
		logic [3:0] cy [15] = '{4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h3, 4'h4, 4'h8, 4'h5, 4'h4, 4'h2, 4'h3,
			4'h3, 4'h4};
		logic tk [15] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
		int n;
		for (int i = 0; i < 15; i++) begin
			wen = i[0];
			issue(ops[i], tk[i], n);
			chk(16'(n), 16'(cy[i]));
			@(negedge clk);
			chk(16'(lcyc), 16'(cy[i]));
			chk(16'(lop), 16'(ops[i]));
		end
		// Byte lengths of the fifteen opcodes add up to 26 fetch clocks
		chk(16'(nfet), 16'h001A);
		// One code read, and only the write issued with the enable high
		chk(16'(nrd), 16'h0001);
		chk(16'(nwr), 16'h0001);
	endtask
	// Breakpoint halt, grants, resume, step and watchpoint
	task automatic t_debug;
		int n;
		brk = '{1'b1, 16'h0100};
		pc = 16'h0100;
		@(negedge clk);
		vld = 1;
		repeat (3) @(negedge clk);
		chk(hlt, 1'b1);
		chk(rdy, 1'b0);
		host.req(1);
		// Grants are combinational; let them settle before looking
		#1;
		chk(16'(agnt), 16'h0001);
		chk(16'(pgnt), 16'h0001);
		host.req(0);
		#1;
		chk(16'(agnt), 16'h0000);
		chk(16'(pgnt), 16'h0000);
		@(negedge clk);
		vld = 0;
		host.pulse(3'h2);
		issue(8'h00, 0, n);
		chk(16'(n), 16'h1);
		brk = '0;
		host.pulse(3'h4);
		repeat (3) @(negedge clk);
		chk(hlt, 1'b1);
		n = ndone;
		vld = 1;
		host.pulse(3'h1);
		repeat (4) @(negedge clk);
		vld = 0;
		chk(16'(ndone - n), 16'h1);
		chk(hlt, 1'b1);
		host.pulse(3'h2);
		wat = '{1'b1, 16'h0040};
		dstb = 1;
		daddr = 16'h0040;
		@(negedge clk);
		dstb = 0;
		repeat (3) @(negedge clk);
		chk(hlt, 1'b1);
		host.pulse(3'h2);
		@(negedge clk);
		chk(hlt, 1'b0);
	endtask
	initial begin
		#20000;
		errors++;
		summarize();
	end
	initial begin
		rst_n = 1'b0;
		vld   = 1'b0;
		btk   = 1'b0;
		wen   = 1'b0;
		dstb  = 1'b0;
		op    = 8'h00;
		pc    = 16'h0000;
		daddr = 16'h0000;
		brk   = '0;
		wat   = '0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		t_timing();
		t_debug();
		summarize();
	end
endmodule
